// >>> rtl/sspg_pkg.sv
// Shared constants and carrier types for the supervisor status and gating block.
// Assumes a single 20 MHz clock and an AHB-Lite register port with 32-bit data.
package sspg_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ctrl_addr   = 8'h00;
   localparam logic [7:0] status_addr = 8'h04;
   localparam logic [7:0] flags_addr  = 8'h08;
   localparam logic [7:0] kicks_addr  = 8'h0c;
   localparam int         addr_w      = 8;
   // Control fields
   localparam int ctrl_wd_enable_bit  = 0;
   localparam int ctrl_wd_clear_bit   = 1;
   localparam logic [31:0] ctrl_reset = 32'h0000_0001;
   // Status fields
   localparam int st_timeout_bit  = 0;
   localparam int st_ce_gate_bit  = 1;
   localparam int st_warn_bit     = 2;
   localparam int st_batt_bit     = 3;
   localparam int st_backup_bit   = 4;
   localparam int st_reset_bit    = 5;
   localparam int st_lowline_bit  = 6;
   localparam int st_wd_level_bit = 7;
   // ****************************************************************
   // AHB constants
   // ****************************************************************
   localparam logic [1:0] htrans_nonseq = 2'b10;
   localparam logic [2:0] hsize_word    = 3'b010;
   localparam logic [31:0] zero_word    = 32'h0000_0000;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int clock_hz        = 20_000_000;
   // Watchdog period in ms, as the default long timeout
   localparam int wd_period_ms    = 1600;
   localparam int wd_period_cyc   = (clock_hz / 1000) * wd_period_ms;
   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic below_reset;
      logic below_batt;
      logic pf_sense_low;
   } sspg_analog_type;
   typedef struct packed {
      logic watchdog_timeout_status_n;
      logic ce_out_n;
      logic power_fail_warning_n;
      logic battery_active_out;
      logic reset_out_n;
      logic reset_out;
      logic low_line_n;
   } sspg_outs_type;
   typedef enum {
      sspg_wd_run,
      sspg_wd_expired
   } sspg_wd_state_type;
endpackage : sspg_pkg

// >>> rtl/sspg_wd_timer.sv
// Watchdog expiry counter for the supervisor status block.
// Assumes the parent gives a restart pulse on every watchdog input edge outside backup.
`timescale 1ns/1ps
module sspg_wd_timer #(
   parameter int period_cyc = sspg_pkg::wd_period_cyc
) (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic enable,
   input  wire logic restart,
   output logic      expire
);
   localparam int cnt_w = $clog2(period_cyc + 1);
   localparam logic [cnt_w-1:0] last = cnt_w'(period_cyc - 1);
   logic [cnt_w-1:0] count_q;
   logic [cnt_w-1:0] count_d;
   logic             expire_q;
   logic             expire_d;

   always_comb
   begin
      count_d  = count_q;
      expire_d = 1'b0;
      if (restart || !enable)
      begin
         count_d = '0;
      end
      else if (count_q == last)
      begin
         // Restarts itself so a stuck input keeps producing timeouts
         count_d  = '0;
         expire_d = 1'b1;
      end
      else
      begin
         count_d = count_q + cnt_w'(1);
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         count_q  <= '0;
         expire_q <= 1'b0;
      end
      else
      begin
         count_q  <= count_d;
         expire_q <= expire_d;
      end
   end

   assign expire = expire_q;
endmodule : sspg_wd_timer

// >>> rtl/sspg_top.sv
// Status outputs, RAM chip-enable gating and power-fail warning of a supply supervisor.
// Assumes analog comparator results arrive as flags synchronous to clock.
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module sspg_top #(
   parameter int wd_period_cyc = sspg_pkg::wd_period_cyc
) (
   input  wire logic                     clock,
   input  wire logic                     srst,
   // AHB-Lite slave
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic      [31:0]              hrdata,
   output logic                          hreadyout,
   output logic                          hresp,
   // Analog flags and pins
   input  wire sspg_pkg::sspg_analog_type analog,
   input  wire logic                     watchdog_kick_in,
   input  wire logic                     ce_in_n,
   input  wire logic                     timebase_in,
   input  wire logic                     timebase_select,
   input  wire logic                     reset_pulse_active,
   output sspg_pkg::sspg_outs_type       outs
);
   // ****************************************************************
   // Mode decode
   // ****************************************************************
   logic backup;
   logic supply_bad;
   assign backup     = analog.below_batt;
   assign supply_bad = analog.below_reset | analog.below_batt;

   // ****************************************************************
   // Register bus
   // ****************************************************************
   logic                     wr_pend_q;
   logic                     wr_pend_d;
   logic [sspg_pkg::addr_w-1:0] addr_q;
   logic [sspg_pkg::addr_w-1:0] addr_d;
   logic [31:0]              ctrl_q;
   logic [31:0]              ctrl_d;
   logic [31:0]              rdata_q;
   logic [31:0]              rdata_d;
   logic [31:0]              kicks_q;
   logic [31:0]              kicks_d;
   logic [31:0]              status_word;
   logic                     take;
   logic                     wd_clear;

   function automatic logic [31:0] read_mux(
      input logic [sspg_pkg::addr_w-1:0] a,
      input logic [31:0]              c,
      input logic [31:0]              s,
      input logic [31:0]              k,
      input sspg_pkg::sspg_analog_type f
   );
      logic [31:0] r;
      r = sspg_pkg::zero_word;
      unique case (a)
         sspg_pkg::ctrl_addr:   r = c;
         sspg_pkg::status_addr: r = s;
         sspg_pkg::flags_addr:  r = {29'h0000_0000, f};
         sspg_pkg::kicks_addr:  r = k;
         default:               r = sspg_pkg::zero_word;
      endcase
      return r;
   endfunction : read_mux

   assign take = hsel && hready && (htrans == sspg_pkg::htrans_nonseq);

   always_comb
   begin
      wr_pend_d = 1'b0;
      addr_d    = addr_q;
      ctrl_d    = ctrl_q;
      rdata_d   = rdata_q;
      wd_clear  = 1'b0;
      if (wr_pend_q && addr_q == sspg_pkg::ctrl_addr)
      begin
         ctrl_d   = sspg_pkg::zero_word;
         ctrl_d[sspg_pkg::ctrl_wd_enable_bit] = hwdata[sspg_pkg::ctrl_wd_enable_bit];
         // Writing the clear bit forces status high unless the timer expires that cycle; the bit is not stored
         wd_clear = hwdata[sspg_pkg::ctrl_wd_clear_bit];
      end
      if (take)
      begin
         addr_d    = haddr[sspg_pkg::addr_w-1:0];
         wr_pend_d = hwrite;
         if (!hwrite)
         begin
            rdata_d = read_mux(haddr[sspg_pkg::addr_w-1:0], ctrl_q, status_word,
                               kicks_q, analog);
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         wr_pend_q <= 1'b0;
         addr_q    <= '0;
         ctrl_q    <= sspg_pkg::ctrl_reset;
         rdata_q   <= sspg_pkg::zero_word;
      end
      else
      begin
         wr_pend_q <= wr_pend_d;
         addr_q    <= addr_d;
         ctrl_q    <= ctrl_d;
         rdata_q   <= rdata_d;
      end
   end

   // Zero wait states; every access is OKAY
   assign hrdata    = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ****************************************************************
   // Watchdog status
   // ****************************************************************
   logic                        kick_prev_q;
   logic                        kick_prev_d;
   logic                        kick_edge;
   logic                        expire;
   sspg_pkg::sspg_wd_state_type wd_state_q;
   sspg_pkg::sspg_wd_state_type wd_state_d;

   // Backup disconnects the input, so no edge is seen there
   assign kick_edge = !backup && (watchdog_kick_in != kick_prev_q);

   sspg_wd_timer #(
      .period_cyc (wd_period_cyc)
   ) u_timer (
      .clock   (clock),
      .srst    (srst),
      .enable  (ctrl_q[sspg_pkg::ctrl_wd_enable_bit] && !backup && !analog.below_reset),
      .restart (kick_edge),
      .expire  (expire)
   );

   always_comb
   begin
      kick_prev_d = watchdog_kick_in;
      kicks_d     = kick_edge ? kicks_q + 32'h0000_0001 : kicks_q;
      wd_state_d  = wd_state_q;
      unique case (wd_state_q)
         sspg_pkg::sspg_wd_run:
         begin
            if (expire && !kick_edge)
            begin
               wd_state_d = sspg_pkg::sspg_wd_expired;
            end
         end
         sspg_pkg::sspg_wd_expired:
         begin
            // A fresh expiry in the same cycle outranks a software clear
            if (kick_edge || (wd_clear && !expire))
            begin
               wd_state_d = sspg_pkg::sspg_wd_run;
            end
         end
      endcase
      if (analog.below_reset || backup)
      begin
         wd_state_d = sspg_pkg::sspg_wd_run;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         kick_prev_q <= 1'b0;
         kicks_q     <= sspg_pkg::zero_word;
         wd_state_q  <= sspg_pkg::sspg_wd_run;
      end
      else
      begin
         kick_prev_q <= kick_prev_d;
         kicks_q     <= kicks_d;
         wd_state_q  <= wd_state_d;
      end
   end

   // ****************************************************************
   // Output stage
   // ****************************************************************
   sspg_pkg::sspg_outs_type outs_q;
   sspg_pkg::sspg_outs_type outs_d;

   // Registered for clean pins; the one-cycle lag is the price of glitch-free gating
   always_comb
   begin
      outs_d.watchdog_timeout_status_n =
         (wd_state_d != sspg_pkg::sspg_wd_expired);
      outs_d.ce_out_n = supply_bad ? 1'b1 : ce_in_n;
      outs_d.power_fail_warning_n = backup ? 1'b0 : !analog.pf_sense_low;
      outs_d.battery_active_out   = backup;
      outs_d.reset_out_n = !(backup || analog.below_reset || reset_pulse_active);
      outs_d.reset_out   = backup || analog.below_reset || reset_pulse_active;
      outs_d.low_line_n  = !(backup || analog.below_reset);
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         outs_q <= '{watchdog_timeout_status_n: 1'b1, ce_out_n: 1'b1,
                     power_fail_warning_n: 1'b1, battery_active_out: 1'b0,
                     reset_out_n: 1'b0, reset_out: 1'b1, low_line_n: 1'b1};
      end
      else
      begin
         outs_q <= outs_d;
      end
   end

   assign outs = outs_q;

   always_comb
   begin
      status_word = sspg_pkg::zero_word;
      status_word[sspg_pkg::st_timeout_bit]  = !outs_q.watchdog_timeout_status_n;
      status_word[sspg_pkg::st_ce_gate_bit]  = supply_bad;
      status_word[sspg_pkg::st_warn_bit]     = outs_q.power_fail_warning_n;
      status_word[sspg_pkg::st_batt_bit]     = outs_q.battery_active_out;
      status_word[sspg_pkg::st_backup_bit]   = backup;
      status_word[sspg_pkg::st_reset_bit]    = outs_q.reset_out;
      status_word[sspg_pkg::st_lowline_bit]  = outs_q.low_line_n;
      status_word[sspg_pkg::st_wd_level_bit] = kick_prev_q;
   end

   // Timebase pins are kept for pin compatibility; period is fixed here
   logic unused_timebase;
   assign unused_timebase = timebase_in ^ timebase_select ^ hsize[0];
endmodule : sspg_top

// >>> verif/sspg_ram_model.sv
// Battery-backed RAM seen only through its gated chip-enable pin.
// Assumes the enable is active low and looked at on the system clock.
`timescale 1ns/1ps
module sspg_ram_model (
   input  wire logic clock,
   input  wire logic ce_n,
   output int        accesses
);
   // ****************************************************************
   // Access counter
   // ****************************************************************
   int count_q = 0;
   // Any cycle with the enable low counts as one access
   always @(posedge clock)
   begin
      if (ce_n === 1'b0)
         count_q <= count_q + 1;
   end
   assign accesses = count_q;
endmodule : sspg_ram_model

// >>> verif/sspg_props.sv
// Port checker for the supervisor status and gating block.
// Assumes a short watchdog period handed on through the bind.
`timescale 1ns/1ps
module sspg_props #(
   parameter int wd_period_cyc = 20
) (
   input wire logic                      clock,
   input wire logic                      srst,
   input wire logic                      hsel,
   input wire logic                      hreadyout,
   input wire logic                      hresp,
   input wire sspg_pkg::sspg_analog_type analog,
   input wire logic                      watchdog_kick_in,
   input wire logic                      ce_in_n,
   input wire sspg_pkg::sspg_outs_type   outs
);
   // ****************************************************************
   // Helper state
   // ****************************************************************
   logic [1:0]  kick_h_q;
   logic [15:0] quiet_q;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // Bus traffic may clear the timeout, so it restarts the quiet count
   always_ff @(posedge clock)
   begin
      kick_h_q <= {kick_h_q[0], watchdog_kick_in};
      if (srst || hsel || analog.below_reset || analog.below_batt
          || watchdog_kick_in != kick_h_q[0])
         quiet_q <= 16'h0000;
      else if (quiet_q != 16'hffff)
         quiet_q <= quiet_q + 16'h0001;
   end
   sequence timeout_rises;
      ##[1:2] outs.watchdog_timeout_status_n;
   endsequence
   // ****************************************************************
   // Assertions
   // ****************************************************************
   ce_follow_a: assert property (!analog.below_reset && !analog.below_batt
      |=> outs.ce_out_n == $past(ce_in_n)) else $error("gated enable not following input");
   ce_gate_a: assert property (analog.below_reset || analog.below_batt
      |=> outs.ce_out_n) else $error("gated enable not forced high");
   warn_follow_a: assert property (!analog.below_batt
      |=> outs.power_fail_warning_n == !$past(analog.pf_sense_low)) else $error("warning wrong");
   backup_levels_a: assert property (analog.below_batt |=> outs.reset_out
      && !outs.reset_out_n && !outs.low_line_n && outs.battery_active_out
      && outs.watchdog_timeout_status_n && !outs.power_fail_warning_n) else $error("backup");
   batt_follow_a: assert property (1'b1
      |=> outs.battery_active_out == $past(analog.below_batt)) else $error("battery flag");
   timeout_force_a: assert property (analog.below_reset
      |=> outs.watchdog_timeout_status_n) else $error("timeout status not forced high");
   timeout_kick_a: assert property (!outs.watchdog_timeout_status_n
      && watchdog_kick_in != kick_h_q[0] |-> timeout_rises) else $error("kick did not clear");
   timeout_hold_a: assert property (!outs.watchdog_timeout_status_n && !hsel
      && !$past(hsel) && watchdog_kick_in == kick_h_q[0] && kick_h_q[0] == kick_h_q[1]
      && !analog.below_reset && !analog.below_batt
      |=> !outs.watchdog_timeout_status_n) else $error("timeout status released early");
   timeout_expire_a: assert property (quiet_q == wd_period_cyc + 6
      |-> !outs.watchdog_timeout_status_n) else $error("timeout not flagged");
   bus_okay_a: assert property (hreadyout && !hresp) else $error("bus response not okay");
endmodule : sspg_props
bind sspg_top sspg_props #(.wd_period_cyc(wd_period_cyc)) sspg_props_i (.clock(clock),
   .srst(srst), .hsel(hsel), .hreadyout(hreadyout), .hresp(hresp), .analog(analog),
   .watchdog_kick_in(watchdog_kick_in), .ce_in_n(ce_in_n), .outs(outs));

// >>> verif/supervisor_status_and_ram_gating_bench.sv
// Self-checking bench for the supervisor status and gating block.
// Assumes the bus slave always answers at once and a short watchdog period.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
   $display("FAIL %0t value mismatch", $time); end end
module supervisor_status_and_ram_gating_bench;
   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   localparam int wd = 20;
   logic clock = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, kick = 1'b0, ce_n = 1'b1;
   logic tb_in = 1'b0, tb_sel = 1'b0, rpa = 1'b0, hreadyout, hresp, e_ok = 1'b0;
   logic e_ce, e_pf, e_bt, e_rs, e_ll;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd, r;
   logic [1:0]  htrans = 2'b00;
   sspg_pkg::sspg_analog_type analog = 3'b000;
   sspg_pkg::sspg_outs_type   outs;
   int seed = 91, miscompares = 0, n_compared = 0, cycles = 0, accesses, a0;
   always #25 clock = ~clock;
   sspg_top #(.wd_period_cyc(wd)) sspg_top_i (.clock(clock), .srst(srst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(sspg_pkg::hsize_word),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .analog(analog), .watchdog_kick_in(kick), .ce_in_n(ce_n),
      .timebase_in(tb_in), .timebase_select(tb_sel), .reset_pulse_active(rpa), .outs(outs));
   sspg_ram_model sspg_ram_model_i (.clock(clock), .ce_n(outs.ce_out_n), .accesses(accesses));
   // ****************************************************************
   // Reference model, compared every cycle
   // ****************************************************************
   always @(posedge clock)
   begin
      e_ok <= !srst;
      e_ce <= (analog.below_reset | analog.below_batt) ? 1'b1 : ce_n;
      e_pf <= analog.below_batt ? 1'b0 : !analog.pf_sense_low;
      e_bt <= analog.below_batt;
      e_rs <= analog.below_reset | analog.below_batt | rpa;
      e_ll <= ~(analog.below_reset | analog.below_batt);
   end
   always @(negedge clock)
   begin
      if (e_ok === 1'b1)
      begin
         `CHK(outs.ce_out_n, e_ce)
         `CHK(outs.power_fail_warning_n, e_pf)
         `CHK(outs.battery_active_out, e_bt)
         `CHK(outs.reset_out, e_rs)
         `CHK(outs.reset_out_n, ~e_rs)
         `CHK(outs.low_line_n, e_ll)
      end
   end
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= sspg_pkg::htrans_nonseq;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   // Hold every input still long enough for the timer to run out
   task automatic starve;
      repeat (wd + 8) @(posedge clock);
      @(negedge clock);
      `CHK(outs.watchdog_timeout_status_n, 1'b0)
   endtask : starve
   always @(posedge clock)
   begin
      cycles++;
      if (cycles > 4000)
      begin
         miscompares++;
         wrap_up();
      end
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      repeat (10) @(posedge clock);
      `CHK(outs.watchdog_timeout_status_n, 1'b1)
      srst <= 1'b0;
      ahb(1'b0, sspg_pkg::ctrl_addr, 32'h0000_0000);
      `CHK(rd, sspg_pkg::ctrl_reset)
      ahb(1'b0, 8'h10, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      $display("test registers done");
      repeat (300)
      begin
         @(posedge clock);
         r = $random(seed);
         analog <= r[2:0];
         {ce_n, kick, tb_in, tb_sel, rpa} <= r[7:3];
      end
      $display("test random flags done");
      @(posedge clock);
      analog <= 3'b000;
      starve();
      @(posedge clock);
      kick <= ~kick;
      repeat (3) @(negedge clock);
      `CHK(outs.watchdog_timeout_status_n, 1'b1)
      starve();
      @(posedge clock);
      analog <= 3'b100;
      repeat (2) @(negedge clock);
      `CHK(outs.watchdog_timeout_status_n, 1'b1)
      @(posedge clock);
      analog <= 3'b000;
      starve();
      ahb(1'b1, sspg_pkg::ctrl_addr, 32'h0000_0003);
      @(negedge clock);
      `CHK(outs.watchdog_timeout_status_n, 1'b1)
      $display("test watchdog done");
      @(posedge clock);
      ce_n <= 1'b0;
      analog <= 3'b010;
      repeat (2) @(posedge clock);
      a0 = accesses;
      repeat (10) @(posedge clock);
      ahb(1'b0, sspg_pkg::kicks_addr, 32'h0000_0000);
      r = rd;
      kick <= ~kick;
      ahb(1'b0, sspg_pkg::status_addr, 32'h0000_0000);
      `CHK(rd[sspg_pkg::st_backup_bit], 1'b1)
      `CHK(accesses, a0)
      ahb(1'b0, sspg_pkg::kicks_addr, 32'h0000_0000);
      `CHK(rd, r)
      $display("test backup done");
      wrap_up();
   end
endmodule : supervisor_status_and_ram_gating_bench
